// ===== lcd_panel_timing_generator.sv
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "lcd_timing_consts.svh"
module lcd_panel_timing_generator (
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [5:0] AWADDR,
  input wire logic WVALID,
  output logic WREADY,
  input wire lcd_timing_pkg::word_t WDATA,
  input wire logic [3:0] WSTRB,
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [5:0] ARADDR,
  output logic RVALID,
  input wire logic RREADY,
  output lcd_timing_pkg::word_t RDATA,
  output logic [1:0] RRESP,
  input wire lcd_timing_pkg::pix_t PIXEL_IN,
  output logic FETCH_REQ,
  output logic PIXEL_CLOCK_OUT,
  output logic PIXEL_CLOCK_OE,
  output logic HSYNC_OUT,
  output logic HSYNC_OE,
  output logic VSYNC_OUT,
  output logic VSYNC_OE,
  output logic PANEL_ENABLE_OUT,
  output logic PANEL_ENABLE_OE,
  output lcd_timing_pkg::pix_t PIXEL_DATA_BUS,
  output lcd_timing_pkg::pix_t PIXEL_DATA_OE,
  output logic PANEL_POWER_PIN,
  output logic PANEL_POWER_OE
);
  import lcd_timing_pkg::*;

  function automatic logic [3:0] reg_index(input logic [5:0] addr);
    reg_index = addr[5:2];
  endfunction

  // Window test is one bit wider so start plus length cannot wrap
  function automatic logic in_win(input cnt_t c, input cnt_t s, input cnt_t l);
    in_win = (c >= s) && ({1'b0, c} < ({1'b0, s} + {1'b0, l}));
  endfunction

  word_t regs_q [`REG_COUNT];
  logic aw_got_q, w_got_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [3:0] aw_idx_q;
  logic [1:0] bresp_q, rresp_q;
  word_t rdata_q, status_w;

  // Register bus: address and data may arrive in either order
  wire aw_hs = AWVALID & awready_q;
  wire w_hs = WVALID & wready_q;
  wire aw_have = aw_got_q | aw_hs;
  wire w_have = w_got_q | w_hs;
  wire do_wr = aw_got_q & w_got_q & ~bvalid_q;
  wire ar_hs = ARVALID & arready_q;
  wire [3:0] ar_idx = reg_index(ARADDR);
  wire wr_ok = aw_idx_q < `OFS_STATUS;
  wire rd_ok = ar_idx <= `OFS_STATUS;
  word_t wmask;
  assign wmask = {{8{WSTRB[3]}}, {8{WSTRB[2]}}, {8{WSTRB[1]}}, {8{WSTRB[0]}}};
  word_t wdata_q, wmask_q;

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
      aw_idx_q <= 4'h0;
      wdata_q <= 32'h00000000;
      wmask_q <= 32'h00000000;
    end else begin
      aw_got_q <= aw_have & ~do_wr;
      w_got_q <= w_have & ~do_wr;
      awready_q <= ~(aw_have & ~do_wr);
      wready_q <= ~(w_have & ~do_wr);
      if (aw_hs) aw_idx_q <= reg_index(AWADDR);
      if (w_hs) begin
        wdata_q <= WDATA;
        wmask_q <= wmask;
      end
      if (do_wr) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (BREADY) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read channel; status is live, unmapped answers slave error
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `RESP_OKAY;
    end else begin
      arready_q <= ~(rvalid_q | ar_hs) | (rvalid_q & RREADY & ~ar_hs);
      if (ar_hs) begin
        rvalid_q <= 1'b1;
        rresp_q <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        rdata_q <= !rd_ok ? 32'h00000000 : (ar_idx == `OFS_STATUS) ? status_w : regs_q[ar_idx];
      end else if (RREADY) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Writable registers, one per word; mask resets to all lines on
  genvar gi;
  generate
    for (gi = 0; gi < `REG_COUNT; gi++) begin : g_reg
      always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
          regs_q[gi] <= (gi == `OFS_DMASK) ? `DMASK_RESET : 32'h00000000;
        end else if (do_wr && wr_ok && aw_idx_q == 4'(gi) && gi != `OFS_STATUS) begin
          regs_q[gi] <= (regs_q[gi] & ~wmask_q) | (wdata_q & wmask_q);
        end
      end
    end
  endgenerate

  // Field decode
  // Bus width stays readable but pixels always leave as one 16-bit word
  wire module_on = regs_q[`OFS_CTRL][0];
  wire [2:0] panel_type_sel = regs_q[`OFS_CON2][2:0];
  wire [1:0] stn_bus_width = regs_q[`OFS_CON2][15:14];
  word_t con3;
  assign con3 = regs_q[`OFS_CON3];
  wire cnt_t total_width = regs_q[`OFS_TOTAL][15:0];
  wire cnt_t total_height = regs_q[`OFS_TOTAL][31:16];
  wire cnt_t active_width = regs_q[`OFS_ACTIVE][15:0];
  wire cnt_t active_height = regs_q[`OFS_ACTIVE][31:16];
  wire [7:0] hsync_start = regs_q[`OFS_HSYNC][7:0];
  wire [7:0] hsync_length = regs_q[`OFS_HSYNC][15:8];
  wire [7:0] vsync_start = regs_q[`OFS_VSYNC][7:0];
  wire [7:0] vsync_length = regs_q[`OFS_VSYNC][15:8];
  wire [7:0] horiz_enable_start = regs_q[`OFS_ENST][7:0];
  wire [7:0] vert_enable_start = regs_q[`OFS_ENST][15:8];
  wire cnt_t active_pixel_start = regs_q[`OFS_ACTDA][15:0];
  wire cnt_t active_line_start = regs_q[`OFS_ACTDA][31:16];
  wire pix_t data_line_mask = regs_q[`OFS_DMASK][15:0];
  wire is_tft = panel_type_sel == `TYPE_TFT;
  wire is_stn = panel_type_sel == `TYPE_MSTN || panel_type_sel == `TYPE_CSTN;

  // Pixel clock phase: one pixel every two MCLK cycles
  logic ph_q, mod_q, line_arm_q;
  cnt_t h_q, v_q;
  logic [7:0] line_cnt_q, dly_q;
  wire tick = module_on & ph_q;
  wire h_last = ({1'b0, h_q} + 17'h1) >= {1'b0, total_width};
  wire v_last = ({1'b0, v_q} + 17'h1) >= {1'b0, total_height};
  wire frame_wrap = tick & h_last & v_last;
  wire line_wrap = tick & h_last;

  // Counters held at zero while off
  always_ff @(posedge MCLK) begin
    if (SYS_RST || !module_on) begin
      ph_q <= 1'b0;
      h_q <= 16'h0000;
      v_q <= 16'h0000;
    end else begin
      ph_q <= ~ph_q;
      if (tick) begin
        h_q <= h_last ? 16'h0000 : h_q + 16'h0001;
        if (h_last) v_q <= v_last ? 16'h0000 : v_q + 16'h0001;
      end
    end
  end

  // Windows against the counters
  wire hs_win = in_win(h_q, 16'(hsync_start), 16'(hsync_length));
  wire vs_win = in_win(v_q, 16'(vsync_start), 16'(vsync_length));
  wire en_win = in_win(h_q, 16'(horiz_enable_start), active_width) &
                in_win(v_q, 16'(vert_enable_start), active_height);
  wire data_win = in_win(h_q, active_pixel_start, active_width) &
                  in_win(v_q, active_line_start, active_height);
  wire en_pol = con3[`B_ENPOL];

  en_mode_t en_mode;
  always_comb begin
    if (!is_stn) en_mode = EN_TFT;
    else if (en_pol) en_mode = EN_SHIFT;
    else if (vert_enable_start == 8'h00) en_mode = EN_FRAME;
    else en_mode = EN_LINE;
  end

  // Modulation toggles; line mode delays the flip by the enable start count
  always_ff @(posedge MCLK) begin
    if (SYS_RST || !module_on) begin
      mod_q <= 1'b0;
      line_cnt_q <= 8'h00;
      line_arm_q <= 1'b0;
      dly_q <= 8'h00;
    end else begin
      if (en_mode == EN_FRAME && frame_wrap) mod_q <= ~mod_q;
      if (line_wrap) begin
        line_cnt_q <= (line_cnt_q + 8'h01 >= vert_enable_start) ? 8'h00 : line_cnt_q + 8'h01;
      end
      if (en_mode == EN_LINE && line_wrap && line_cnt_q + 8'h01 >= vert_enable_start) begin
        line_arm_q <= 1'b1;
        dly_q <= horiz_enable_start;
      end else if (line_arm_q) begin
        if (dly_q == 8'h00) begin
          line_arm_q <= 1'b0;
          mod_q <= ~mod_q;
        end else begin
          dly_q <= dly_q - 8'h01;
        end
      end
    end
  end

  // Shift clock is the pixel clock inverted; an odd delay of a period-2 clock
  // is a half period, so delay reduces to one phase bit.
  wire pclk_d = ph_q ^ con3[`B_CLKPOL];
  wire shift_d = ~pclk_d ^ horiz_enable_start[0];
  logic en_d;
  always_comb begin
    unique case (en_mode)
      EN_TFT: en_d = en_win ~^ en_pol;
      EN_SHIFT: en_d = shift_d;
      EN_FRAME: en_d = mod_q;
      EN_LINE: en_d = mod_q;
    endcase
  end

  logic pclk_q, hs_q, vs_q, en_q, fetch_q, pwr_q, pclk_oe_q, hs_oe_q, vs_oe_q, en_oe_q, pwr_oe_q;
  pix_t data_q, data_oe_q;
  wire pads = con3[`B_PADS];

  // Pins: every pad is a flop; data changes with the rising pixel clock while the clock polarity bit is clear
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      pclk_q <= 1'b0;
      hs_q <= 1'b1;
      vs_q <= 1'b1;
      en_q <= 1'b0;
      fetch_q <= 1'b0;
      data_q <= 16'h0000;
      {pclk_oe_q, hs_oe_q, vs_oe_q, en_oe_q, pwr_q, pwr_oe_q} <= 6'h00;
      data_oe_q <= 16'h0000;
    end else begin
      pclk_q <= module_on ? pclk_d : con3[`B_CLKPOL];
      pclk_oe_q <= pads;
      hs_oe_q <= pads & con3[`B_HSUSE];
      vs_oe_q <= pads & con3[`B_VSUSE];
      en_oe_q <= pads & con3[`B_ENUSE];
      data_oe_q <= pads ? data_line_mask : 16'h0000;
      pwr_oe_q <= pads & con3[`B_PWRUSE];
      pwr_q <= con3[`B_PWRLVL];
      fetch_q <= tick & data_win;
      if (!module_on) begin
        hs_q <= ~con3[`B_HSPOL];
        vs_q <= ~con3[`B_VSPOL];
        en_q <= is_stn ? 1'b0 : ~en_pol;
        data_q <= 16'h0000;
      end else begin
        if (tick) begin
          hs_q <= hs_win ~^ con3[`B_HSPOL];
          vs_q <= vs_win ~^ con3[`B_VSPOL];
          data_q <= data_win ? PIXEL_IN : 16'h0000;
        end
        if (tick || en_mode != EN_TFT) en_q <= en_d;
      end
    end
  end

  assign status_w = {v_q[14:0], mod_q, h_q};
  assign AWREADY = awready_q;
  assign WREADY = wready_q;
  assign BVALID = bvalid_q;
  assign BRESP = bresp_q;
  assign ARREADY = arready_q;
  assign RVALID = rvalid_q;
  assign RDATA = rdata_q;
  assign RRESP = rresp_q;
  assign FETCH_REQ = fetch_q;
  assign PIXEL_CLOCK_OUT = pclk_q;
  assign PIXEL_CLOCK_OE = pclk_oe_q;
  assign HSYNC_OUT = hs_q;
  assign HSYNC_OE = hs_oe_q;
  assign VSYNC_OUT = vs_q;
  assign VSYNC_OE = vs_oe_q;
  assign PANEL_ENABLE_OUT = en_q;
  assign PANEL_ENABLE_OE = en_oe_q;
  assign PIXEL_DATA_BUS = data_q;
  assign PIXEL_DATA_OE = data_oe_q;
  assign PANEL_POWER_PIN = pwr_q;
  assign PANEL_POWER_OE = pwr_oe_q;

  // Checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  hcnt_wrap_a: assert property (tick && h_last |=> h_q == 16'h0000)
    else $error("horizontal counter did not wrap");
  hcnt_step_a: assert property (tick && !h_last |=> h_q == $past(h_q) + 16'h0001)
    else $error("horizontal counter did not step");
  off_idle_a: assert property (!module_on ##1 !module_on |-> h_q == 16'h0000 && v_q == 16'h0000 &&
    hs_q == ~$past(con3[`B_HSPOL]))
    else $error("counters or sync active while off");
  hsync_level_a: assert property (module_on && tick ##1 module_on |->
    hs_q == ($past(hs_win) ~^ $past(con3[`B_HSPOL])))
    else $error("hsync level wrong");
  data_zero_a: assert property (tick && !data_win && module_on |=> data_q == 16'h0000)
    else $error("data outside active region");
  data_take_a: assert property (tick && data_win |=> fetch_q && data_q == $past(PIXEL_IN))
    else $error("pixel not presented");
  // First cycle after enable still shows the idle clock level
  pclk_period_a: assert property (module_on ##1 module_on ##1 module_on |->
    pclk_q != $past(pclk_q))
    else $error("pixel clock stalled");
  tft_enable_a: assert property (module_on && en_mode == EN_TFT && en_pol && tick |=>
    en_q == $past(en_win))
    else $error("TFT enable level wrong");
  oe_gate_a: assert property (!pads |=> !hs_oe_q && !vs_oe_q && !en_oe_q && data_oe_q == 16'h0000)
    else $error("pad driven while pads off");
  frame_mod_a: assert property (module_on && en_mode == EN_FRAME && frame_wrap |=>
    mod_q != $past(mod_q))
    else $error("frame toggle missing");
  cov_frame_c: cover property (frame_wrap);
  cov_line_c: cover property (line_arm_q && dly_q == 8'h00);
  // Shift clock sits opposite the latch clock, or in phase for an odd delay
  shift_phase_a: assert property (module_on && en_mode == EN_SHIFT |=>
    (en_q != pclk_q) == !$past(horiz_enable_start[0]))
    else $error("shift clock phase wrong");
  mask_oe_a: assert property (pads |=> data_oe_q == $past(data_line_mask))
    else $error("data line mask not applied");
  line_mod_a: assert property (module_on && line_arm_q && dly_q == 8'h00 &&
    !line_wrap |=> mod_q != $past(mod_q))
    else $error("line toggle missing");
  cov_write_c: cover property (do_wr && aw_idx_q == `OFS_CTRL);
  cov_shift_c: cover property (module_on && en_mode == EN_SHIFT);
endmodule

// ===== lcd_timing_consts.svh
`ifndef LCD_TIMING_CONSTS_SVH
`define LCD_TIMING_CONSTS_SVH
`define OFS_CTRL 4'h0
`define OFS_CON2 4'h1
`define OFS_CON3 4'h2
`define OFS_TOTAL 4'h3
`define OFS_ACTIVE 4'h4
`define OFS_HSYNC 4'h5
`define OFS_VSYNC 4'h6
`define OFS_ENST 4'h7
`define OFS_ACTDA 4'h8
`define OFS_DMASK 4'h9
`define OFS_STATUS 4'hA
`define REG_COUNT 11
`define TYPE_TFT 3'h1
`define TYPE_MSTN 3'h2
`define TYPE_CSTN 3'h3
`define B_CLKPOL 0
`define B_ENUSE 1
`define B_ENPOL 2
`define B_VSUSE 3
`define B_HSUSE 4
`define B_VSPOL 5
`define B_HSPOL 6
`define B_PADS 7
`define B_PWRLVL 8
`define B_PWRUSE 9
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define DMASK_RESET 32'h0000FFFF
`endif

// ===== lcd_timing_pkg.sv
package lcd_timing_pkg;
  typedef logic [31:0] word_t;
  typedef logic [15:0] pix_t;
  typedef logic [15:0] cnt_t;
  typedef enum logic [1:0] {
    EN_TFT = 2'b00,
    EN_SHIFT = 2'b01,
    EN_FRAME = 2'b10,
    EN_LINE = 2'b11
  } en_mode_t;
endpackage

// ===== panel_model.sv
`timescale 1ns/1ps
module panel_model (
  input wire logic pclk,
  input wire logic hs,
  input wire logic vs,
  input wire logic en,
  input wire lcd_timing_pkg::pix_t data,
  input wire logic hs_pol,
  input wire logic vs_pol,
  input wire logic en_pol,
  output int frames,
  output int f_len,
  output int f_hs,
  output int f_vs,
  output int f_en,
  output int f_tog,
  output int f_dat,
  output lcd_timing_pkg::pix_t first_dat
);
  import lcd_timing_pkg::*;
  int n[6];
  logic vs_q = 1'b0;
  logic en_q = 1'b0;
  initial frames = 0;
  // Glass samples mid-pixel, just after the fall so every pin has settled;
  // a frame opens where vsync turns active
  always @(negedge pclk) begin
    #1;
    if (vs === vs_pol && !vs_q) begin
      f_len = n[0];
      f_hs = n[1];
      f_vs = n[2];
      f_en = n[3];
      f_tog = n[4];
      f_dat = n[5];
      first_dat = data;
      frames++;
      n = '{default: 0};
    end
    vs_q = (vs === vs_pol);
    n[0]++;
    n[1] += (hs === hs_pol);
    n[2] += vs_q;
    n[3] += (en === en_pol);
    n[4] += ((en === en_pol) != en_q);
    en_q = (en === en_pol);
    n[5] += (data !== 16'h0000); // Blank pixels must read zero
  end
endmodule

// ===== tb.sv
`timescale 1ns/1ps
`include "lcd_timing_consts.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb;
  import lcd_timing_pkg::*;
  localparam int TW = 20;
  localparam int TH = 12;
  localparam int AW = 12;
  localparam int AH = 8;
  logic MCLK = 0, SYS_RST = 1, AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
  logic [5:0] AWADDR = 0, ARADDR = 0;
  logic [3:0] WSTRB = 4'hF;
  word_t WDATA = 0, RDATA, rv, con3;
  pix_t PIXEL_IN = 16'h8001, PIXEL_DATA_BUS, PIXEL_DATA_OE, first_dat;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, FETCH_REQ, PIXEL_CLOCK_OUT, PIXEL_CLOCK_OE;
  logic HSYNC_OUT, HSYNC_OE, VSYNC_OUT, VSYNC_OE, PANEL_ENABLE_OUT, PANEL_ENABLE_OE;
  logic PANEL_POWER_PIN, PANEL_POWER_OE;
  logic [1:0] BRESP, RRESP, resp;
  int failures = 0, total_checks = 0, fetches = 0, f0, k;
  int frames, f_len, f_hs, f_vs, f_en, f_tog, f_dat;
  word_t seed = 32'h5222;
  // type, enable pol, h/v enable start, active start, hs start/len, vs start/len, en count, toggles
  int cfg[6][11] = '{'{1, 1, 6, 3, 4, 2, 3, 1, 2, 96, 16}, '{1, 0, 0, 0, 0, 0, 1, 0, 1, 96, 16},
    '{2, 1, 0, 0, 4, 1, 4, 0, 1, 240, 0}, '{3, 1, 1, 0, 4, 1, 4, 0, 1, 0, 0},
    '{2, 0, 5, 0, 0, 1, 4, 0, 1, -1, 1}, '{3, 0, 2, 3, 0, 1, 4, 0, 1, -1, 4}};

  lcd_panel_timing_generator uut (.MCLK, .SYS_RST, .AWVALID, .AWREADY, .AWADDR, .WVALID, .WREADY,
    .WDATA, .WSTRB, .BVALID, .BREADY, .BRESP, .ARVALID, .ARREADY, .ARADDR, .RVALID, .RREADY,
    .RDATA, .RRESP, .PIXEL_IN, .FETCH_REQ, .PIXEL_CLOCK_OUT, .PIXEL_CLOCK_OE, .HSYNC_OUT,
    .HSYNC_OE, .VSYNC_OUT, .VSYNC_OE, .PANEL_ENABLE_OUT, .PANEL_ENABLE_OE, .PIXEL_DATA_BUS,
    .PIXEL_DATA_OE, .PANEL_POWER_PIN, .PANEL_POWER_OE);

  panel_model pm (.pclk(PIXEL_CLOCK_OUT), .hs(HSYNC_OUT), .vs(VSYNC_OUT), .en(PANEL_ENABLE_OUT),
    .data(PIXEL_DATA_BUS), .hs_pol(con3[6]), .vs_pol(con3[5]), .en_pol(con3[2]), .frames,
    .f_len, .f_hs, .f_vs, .f_en, .f_tog, .f_dat, .first_dat);

  always #2.5 MCLK = ~MCLK;

  function automatic word_t xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Frame buffer side: next nonzero pixel once the current one is taken
  always @(posedge MCLK) if (FETCH_REQ) PIXEL_IN <= 16'(xs()) | 16'h8001;
  // Fetch count on the far edge, clear of the launching edge
  always @(negedge MCLK) if (FETCH_REQ) fetches++;

  task automatic wr(input logic [5:0] a, input word_t d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge MCLK);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(posedge MCLK);
      n++;
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end while (BVALID !== 1'b1 && n < 300);
    r = BRESP;
    BREADY <= 1'b0;
    if (n >= 300) failures++;
  endtask

  task automatic rd(input logic [5:0] a, output word_t d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge MCLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(posedge MCLK);
      n++;
      if (ARREADY) ARVALID <= 1'b0;
    end while (RVALID !== 1'b1 && n < 300);
    d = RDATA;
    r = RRESP;
    RREADY <= 1'b0;
    if (n >= 300) failures++;
  endtask

  task automatic wrap_up();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Hang guard, well beyond six short configurations
  initial begin
    #(40000 * 5);
    failures++;
    wrap_up();
  end

  initial begin
    con3 = 0;
    repeat (10) @(posedge MCLK);
    SYS_RST <= 1'b0;
    rd({`OFS_DMASK, 2'b00}, rv, resp);
    `CHK("mask reset", `DMASK_RESET, rv)
    rd({`OFS_CTRL, 2'b00}, rv, resp);
    `CHK("ctrl reset", 32'h0, rv)
    rd(6'h2C, rv, resp);
    `CHK("unmapped read", `RESP_SLVERR, resp)
    wr({`OFS_STATUS, 2'b00}, 32'h0, resp);
    `CHK("status write", `RESP_SLVERR, resp)
    for (int t = 0; t < 6; t++) begin
      rv = xs();
      con3 = (rv & 32'h37A) | 32'h80 | (cfg[t][1] << 2);
      wr({`OFS_CON2, 2'b00}, (rv & 32'hC000) | cfg[t][0], resp);
      wr({`OFS_CON3, 2'b00}, con3, resp);
      wr({`OFS_TOTAL, 2'b00}, (TH << 16) | TW, resp);
      wr({`OFS_ACTIVE, 2'b00}, (AH << 16) | AW, resp);
      wr({`OFS_HSYNC, 2'b00}, (cfg[t][6] << 8) | cfg[t][5], resp);
      wr({`OFS_VSYNC, 2'b00}, (cfg[t][8] << 8) | cfg[t][7], resp);
      wr({`OFS_ENST, 2'b00}, (cfg[t][3] << 8) | cfg[t][2], resp);
      wr({`OFS_ACTDA, 2'b00}, (cfg[t][4] << 16) | cfg[t][4], resp);
      wr({`OFS_DMASK, 2'b00}, rv >> 16, resp);
      wr({`OFS_CTRL, 2'b00}, 32'h1, resp);
      repeat (4) @(posedge MCLK);
      `CHK("hsync oe", con3[4], HSYNC_OE)
      `CHK("vsync oe", con3[3], VSYNC_OE)
      `CHK("enable oe", con3[1], PANEL_ENABLE_OE)
      `CHK("clock oe", 1'b1, PIXEL_CLOCK_OE)
      `CHK("data oe", rv[31:16], PIXEL_DATA_OE)
      `CHK("power oe", con3[9], PANEL_POWER_OE)
      `CHK("power pin", con3[8], PANEL_POWER_PIN)
      f0 = frames;
      k = 0;
      while (frames < f0 + 2 && k < 5000) begin
        @(posedge MCLK);
        k++;
      end
      if (k >= 5000) failures++;
      k = fetches;
      repeat (2 * TW * TH) @(posedge MCLK);
      `CHK("fetches", AW * AH, fetches - k)
      `CHK("frame length", TW * TH, f_len)
      `CHK("hsync pixels", cfg[t][6] * TH, f_hs)
      `CHK("vsync pixels", cfg[t][8] * TW, f_vs)
      if (cfg[t][9] >= 0) `CHK("enable pixels", cfg[t][9], f_en)
      `CHK("enable toggles", cfg[t][10], f_tog)
      `CHK("data pixels", AW * AH, f_dat)
      if (t == 1) `CHK("first pixel", 1'b1, |first_dat)
      rd({`OFS_CON2, 2'b00}, rv, resp);
      `CHK("panel type", 3'(cfg[t][0]), rv[2:0])
      wr({`OFS_CTRL, 2'b00}, 32'h0, resp);
      repeat (4) @(posedge MCLK);
      `CHK("hsync idle", ~con3[6], HSYNC_OUT)
      `CHK("vsync idle", ~con3[5], VSYNC_OUT)
      `CHK("enable idle", cfg[t][0] == 1 && cfg[t][1] == 0, PANEL_ENABLE_OUT)
      `CHK("data idle", 16'h0000, PIXEL_DATA_BUS)
      rd({`OFS_STATUS, 2'b00}, rv, resp);
      `CHK("counters idle", 32'h0, rv & 32'hFFFEFFFF)
      $display("test %0d done", t);
    end
    wrap_up();
  end
endmodule
